// file: inc/nibble_cpu_pkg.sv
// Purpose: shared constants for the pointer and branch decode core
// Assumes: one byte of program memory per fetch address
// Notes:   opcodes are full bytes or upper-bit patterns
package nibble_cpu_pkg;
   localparam int PC_W        = 12;
   localparam int STACK_DEPTH = 8;
   localparam int BANKS       = 4;
   localparam int WREGS       = 8;
   localparam int FLAGS       = 16;

   localparam logic [11:0] RST_PC  = 12'h000;
   localparam logic [3:0]  RST_NIB = 4'h0;
   localparam logic [1:0]  RST_BANK = 2'h0;
   localparam logic [7:0]  RST_GATES = 8'h00;

   // working register slots inside one bank
   localparam logic [1:0] SLOT_SUM = 2'h0;
   localparam logic [1:0] SLOT_HI  = 2'h2;
   localparam logic [1:0] SLOT_LO  = 2'h3;

   // whole-byte opcodes
   localparam logic [7:0] OP_NOP    = 8'h00;
   localparam logic [7:0] OP_IND    = 8'hEE;
   localparam logic [7:0] OP_DED    = 8'hEF;
   localparam logic [7:0] OP_TAL    = 8'hF7;
   localparam logic [7:0] OP_TLA    = 8'hE9;
   localparam logic [7:0] OP_XAH    = 8'h23;
   localparam logic [7:0] OP_COMMIT_BANK_SELECT   = 8'hF2;
   localparam logic [7:0] OP_INDEXED_PAGE_JUMP   = 8'hFA;
   localparam logic [7:0] OP_RT     = 8'h62;
   localparam logic [7:0] OP_RTI    = 8'h22;
   localparam logic [7:0] OP_BANK   = 8'hFD;
   localparam logic [7:0] OP_IP     = 8'h0C;
   localparam logic [7:0] OP_OP     = 8'h61;
   localparam logic [7:0] OP_HALT   = 8'hF6;
   localparam logic [7:0] OP_CTL    = 8'h2C;
   localparam logic [7:0] OP_BC     = 8'h3E;
   localparam logic [7:0] OP_BNC    = 8'h3F;
   localparam logic [7:0] OP_BZ     = 8'h7E;
   localparam logic [7:0] OP_BNZ    = 8'h7F;

   // upper-nibble opcodes
   localparam logic [3:0] HI_LDZ = 4'h8;
   localparam logic [3:0] HI_LHI = 4'h4;
   localparam logic [3:0] HI_SFB = 4'h5;
   localparam logic [3:0] HI_RFB = 4'h1;
   localparam logic [3:0] HI_CZP = 4'hB;
   localparam logic [3:0] HI_BF  = 4'hD;
   localparam logic [3:0] HI_BNF = 4'h9;
   localparam logic [3:0] HI_BSET = 4'h7;
   localparam logic [3:0] HI_BCLR = 4'h3;
   localparam logic [3:0] HI_XA  = 4'hE;
   localparam logic [3:0] HI_XP  = 4'hF;
   localparam logic [3:0] CTL_SET_HI = 4'h4;
   localparam logic [3:0] CTL_CLR_HI = 4'h5;
   localparam logic [3:0] CTL_GLOBAL = 4'h8;

   // partial patterns
   localparam logic [4:0] PAT_JMP = 5'b01101;
   localparam logic [4:0] PAT_CAL = 5'b10101;
   localparam logic [5:0] PAT_SB  = 6'b011001;
   localparam logic [5:0] PAT_SPB = 6'b000001;
   localparam logic [5:0] PAT_RPB = 6'b001001;
   localparam logic [6:0] PAT_XH  = 7'b1111100;

   typedef enum logic [1:0] {ST_EXEC, ST_SECOND, ST_PBIT, ST_HALT} cpu_state_type;
endpackage

// file: verilog/call_stack.sv
// Purpose: return address stack for calls and returns
// Assumes: caller never pushes and pops in one cycle
// Notes:   overflow wraps and overwrites the oldest entry
`timescale 1ns/10ps
`default_nettype none
module call_stack
   import nibble_cpu_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
)
(
   // clock and reset
   input  wire logic            ref_clk,
   input  wire logic            rst_n,
   // stack access
   input  wire logic            push,
   input  wire logic            pop,
   input  wire logic [PC_W-1:0] push_data,
   output logic      [PC_W-1:0] top
);
   localparam int PW = $clog2(DEPTH);

   logic [PC_W-1:0] mem_ff [DEPTH];
   logic [PW-1:0]   sp_ff;
   logic [PW-1:0]   below;

   // refused at elaboration: the pointer wraps only for power-of-two depths
   if (DEPTH < 2 || (1 << PW) != DEPTH)
   begin : g_depth_chk
      $error("call_stack depth must be a power of two");
   end

   assign below = sp_ff - PW'(1);
   assign top   = mem_ff[below];

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sp_ff <= '0;
         for (int i = 0; i < DEPTH; i++)
            mem_ff[i] <= RST_PC;
      end
      else if (push)
      begin
         mem_ff[sp_ff] <= push_data;
         sp_ff         <= sp_ff + PW'(1);
      end
      else if (pop)
         sp_ff <= below;
   end
endmodule
`default_nettype wire

// file: verilog/bank_file.sv
// Purpose: banked working registers and flags
// Assumes: one register write and one flag write per cycle
// Notes:   flag group output gives the aligned group of four flags holding the selected one
`timescale 1ns/10ps
`default_nettype none
module bank_file
   import nibble_cpu_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // bank in use
   input  wire logic [1:0] bank,
   // working registers
   input  wire logic [2:0] rd_idx,
   output logic      [3:0] rd_data,
   input  wire logic       wr_en,
   input  wire logic [3:0] wr_data,
   // flags
   input  wire logic [3:0] flag_idx,
   input  wire logic       flag_we,
   input  wire logic       flag_val,
   output logic            flag_rd,
   output logic      [3:0] flag_grp
);
   logic [3:0]       wreg_ff [BANKS][WREGS];
   logic [FLAGS-1:0] flag_ff [BANKS];

   assign rd_data  = wreg_ff[bank][rd_idx];
   assign flag_rd  = flag_ff[bank][flag_idx];
   assign flag_grp = flag_ff[bank][{flag_idx[3:2], 2'b00} +: 4];

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int b = 0; b < BANKS; b++)
         begin
            flag_ff[b] <= '0;
            for (int r = 0; r < WREGS; r++)
               wreg_ff[b][r] <= RST_NIB;
         end
      end
      else
      begin
         if (wr_en)
            wreg_ff[bank][rd_idx] <= wr_data;
         if (flag_we)
            flag_ff[bank][flag_idx] <= flag_val;
      end
   end
endmodule
`default_nettype wire

// file: verilog/nibble_cpu_core.sv
// Purpose: pointer, exchange, flag, branch, call, port and control decode
// Assumes: rom_data, mem_rdata and io_rdata answer combinationally
// Notes:   opcodes outside this group run as one-cycle no-ops
// Operation
// - zero-load and high-load set pointer nibbles
// - low pointer step updates zero bit
// - sum and low pointer transfers
// - swap sum with high pointer
// - swap sum with banked working register
// - swap pointer nibble with banked register
// - commit staged bank into bank select
// - stage two-bit bank value
// - set or clear banked flag
// - long jump keeps or inverts top bit
// - indexed jump from E and sum
// - page zero call with four-bit target
// - bank zero call, two bytes
// - returns pop stack, irq restores flags
// - bank change modifies next jump or port
// - bit-test branches on sum, memory, port
// - carry and zero conditional branches
// - branches on banked flag bits
// - port read and write via pointer
// - port bit set/clear, E destroyed
// - irq enable set and clear
// - halt to standby, no-op idles
// - irq selector only zero through eight
`timescale 1ns/10ps
`default_nettype none
module nibble_cpu_core
   import nibble_cpu_pkg::*;
(
   // clock and reset
   input  wire logic            ref_clk,
   input  wire logic            rst_n,
   // program memory
   output logic      [PC_W-1:0] rom_addr,
   input  wire logic [7:0]      rom_data,
   // data memory
   output logic      [7:0]      mem_addr,
   input  wire logic [3:0]      mem_rdata,
   // ports and pseudo ports
   output logic      [7:0]      io_addr,
   output logic                 io_pseudo,
   input  wire logic [3:0]      io_rdata,
   output logic      [3:0]      io_wdata,
   output logic                 io_we,
   // saved flags from interrupt entry
   input  wire logic            saved_carry,
   input  wire logic            saved_zero,
   // standby
   output logic                 standby,
   input  wire logic            wake,
   // visible state
   output logic      [3:0]      main_sum_nibble,
   output logic      [3:0]      e_nibble,
   output logic      [7:0]      mem_pointer,
   output logic                 carry_bit,
   output logic                 zero_bit,
   output logic      [1:0]      bank_select_bits,
   output logic      [7:0]      irq_gate_bits,
   output logic                 global_irq_gate
);
   cpu_state_type   st_ff, nxt_st;
   logic [PC_W-1:0] pc_ff, nxt_pc;
   logic [7:0]      op_ff, nxt_op;
   logic [3:0]      acc_ff, nxt_acc;
   logic [3:0]      e_ff, nxt_e;
   logic [3:0]      dph_ff, nxt_dph;
   logic [3:0]      dpl_ff, nxt_dpl;
   logic            cf_ff, nxt_cf;
   logic            zf_ff, nxt_zf;
   logic [1:0]      rbf_ff, nxt_rbf;
   logic [1:0]      sb_ff, nxt_sb;
   logic            bankp_ff, nxt_bankp;
   logic [7:0]      ctl_ff, nxt_ctl;
   logic            mst_ff, nxt_mst;

   logic            push;
   logic            pop;
   logic [PC_W-1:0] top;
   logic [PC_W-1:0] pc_inc;
   logic [3:0]      rd_data;
   logic            flag_rd;
   logic [3:0]      flag_grp;
   logic            flag_we;
   logic            flag_val;
   logic            done;

   // decode of the byte on the bus in the execute state
   logic [7:0] opc;
   logic [3:0] hi;
   logic [3:0] lo;
   assign opc = rom_data;
   assign hi  = opc[7:4];
   assign lo  = opc[3:0];

   logic is_ldz, is_lhi, is_sfb, is_rfb, is_czp, is_sb, is_xa, is_xh, is_xl;
   logic is_jmp, is_cal, is_btst, is_bcz, is_bf, is_ctl, is_pbit, two_byte;
   assign is_ldz  = hi == HI_LDZ;
   assign is_lhi  = hi == HI_LHI;
   assign is_sfb  = hi == HI_SFB;
   assign is_rfb  = hi == HI_RFB;
   assign is_czp  = hi == HI_CZP;
   assign is_sb   = opc[7:2] == PAT_SB;
   assign is_xa   = hi == HI_XA && lo[1:0] == 2'b00 && lo != 4'hC;
   assign is_xh   = opc[7:1] == PAT_XH;
   assign is_xl   = hi == HI_XP && (lo == 4'h0 || lo == 4'h4);
   assign is_jmp  = opc[7:3] == PAT_JMP;
   assign is_cal  = opc[7:3] == PAT_CAL;
   assign is_btst = (hi == HI_BSET || hi == HI_BCLR) && lo[3:2] != 2'b11;
   assign is_bcz  = opc == OP_BC || opc == OP_BNC || opc == OP_BZ || opc == OP_BNZ;
   assign is_bf   = hi == HI_BF || hi == HI_BNF;
   assign is_ctl  = opc == OP_CTL;
   assign is_pbit = opc[7:2] == PAT_SPB || opc[7:2] == PAT_RPB;
   assign two_byte = is_jmp | is_cal | is_btst | is_bcz | is_bf | is_ctl;

   // exchange register slot and write data
   logic [2:0] rd_idx;
   logic       wr_en;
   logic [3:0] wr_data;
   assign rd_idx  = is_xa ? {1'b0, lo[3:2]}
                  : is_xh ? {SLOT_HI, lo[0]}
                  : {SLOT_LO, lo[2]};
   assign wr_en   = st_ff == ST_EXEC && (is_xa | is_xh | is_xl);
   assign wr_data = is_xa ? acc_ff : is_xh ? dph_ff : dpl_ff;

   // flag selector comes from the latched first byte for flag branches
   logic [3:0] flag_idx;
   assign flag_idx = (st_ff == ST_EXEC) ? lo : op_ff[3:0];

   // second-byte branch condition
   logic [3:0] bsrc;
   logic       bit_sel;
   logic       want;
   logic       take;
   assign bsrc    = op_ff[3:2] == 2'b00 ? acc_ff
                  : op_ff[3:2] == 2'b01 ? mem_rdata : io_rdata;
   assign bit_sel = bsrc[op_ff[1:0]];
   assign want    = op_ff[6];
   assign take    = (op_ff == OP_BC || op_ff == OP_BNC || op_ff == OP_BZ || op_ff == OP_BNZ)
                  ? ((op_ff[6] ? zf_ff : cf_ff) == ~op_ff[0])
                  : (op_ff[7:4] == HI_BF || op_ff[7:4] == HI_BNF) ? (flag_rd == want)
                  : (bit_sel == want);

   // port bit result built from the value parked in E
   logic [3:0] pbit_mask;
   logic [3:0] pbit_val;
   assign pbit_mask = 4'h1 << op_ff[1:0];
   assign pbit_val  = op_ff[5] ? (e_ff & ~pbit_mask) : (e_ff | pbit_mask);

   logic [3:0] dpl_up;
   logic [3:0] dpl_dn;
   logic [3:0] flag_mask;
   assign dpl_up    = dpl_ff + 4'h1;
   assign dpl_dn    = dpl_ff - 4'h1;
   assign flag_mask = 4'h1 << lo[1:0];
   assign pc_inc    = pc_ff + 12'h001;

   always_comb
   begin
      nxt_st    = st_ff;
      nxt_pc    = pc_ff;
      nxt_op    = op_ff;
      nxt_acc   = acc_ff;
      nxt_e     = e_ff;
      nxt_dph   = dph_ff;
      nxt_dpl   = dpl_ff;
      nxt_cf    = cf_ff;
      nxt_zf    = zf_ff;
      nxt_rbf   = rbf_ff;
      nxt_sb    = sb_ff;
      nxt_ctl   = ctl_ff;
      nxt_mst   = mst_ff;
      push      = 1'b0;
      pop       = 1'b0;
      flag_we   = 1'b0;
      flag_val  = 1'b0;
      io_we     = 1'b0;
      io_wdata  = acc_ff;
      done      = 1'b0;
      case (st_ff)
         ST_EXEC:
         begin
            nxt_pc = pc_inc;
            done   = 1'b1;
            if (two_byte)
            begin
               nxt_op = opc;
               nxt_st = ST_SECOND;
               done   = 1'b0;
            end
            else if (is_pbit)
            begin
               nxt_e  = io_rdata;
               nxt_op = opc;
               nxt_st = ST_PBIT;
               done   = 1'b0;
            end
            else if (opc == OP_HALT)
               nxt_st = ST_HALT;
            else if (is_ldz)
            begin
               nxt_dph = RST_NIB;
               nxt_dpl = lo;
            end
            else if (is_lhi)
               nxt_dph = lo;
            else if (opc == OP_IND)
            begin
               nxt_dpl = dpl_up;
               nxt_zf  = dpl_up == 4'h0;
            end
            else if (opc == OP_DED)
            begin
               nxt_dpl = dpl_dn;
               nxt_zf  = dpl_dn == 4'h0;
            end
            else if (opc == OP_TAL)
               nxt_dpl = acc_ff;
            else if (opc == OP_TLA)
            begin
               nxt_acc = dpl_ff;
               nxt_zf  = dpl_ff == 4'h0;
            end
            else if (opc == OP_XAH)
            begin
               nxt_acc = dph_ff;
               nxt_dph = acc_ff;
            end
            else if (is_xa)
               nxt_acc = rd_data;
            else if (is_xh)
               nxt_dph = rd_data;
            else if (is_xl)
               nxt_dpl = rd_data;
            else if (opc == OP_COMMIT_BANK_SELECT)
               nxt_rbf = sb_ff;
            else if (is_sb)
               nxt_sb = lo[1:0];
            else if (is_sfb)
            begin
               flag_we  = 1'b1;
               flag_val = 1'b1;
            end
            else if (is_rfb)
            begin
               flag_we = 1'b1;
               nxt_zf  = (flag_grp & ~flag_mask) == 4'h0;
            end
            else if (opc == OP_INDEXED_PAGE_JUMP)
               nxt_pc = {pc_ff[11:8], e_ff, acc_ff};
            else if (is_czp)
            begin
               push   = 1'b1;
               nxt_pc = {6'h00, lo, 2'b00};
            end
            else if (opc == OP_RT || opc == OP_RTI)
            begin
               pop    = 1'b1;
               nxt_pc = top;
               if (opc == OP_RTI)
               begin
                  nxt_cf = saved_carry;
                  nxt_zf = saved_zero;
               end
            end
            else if (opc == OP_IP)
            begin
               nxt_acc = io_rdata;
               nxt_zf  = io_rdata == 4'h0;
            end
            else if (opc == OP_OP)
               io_we = 1'b1;
         end
         ST_SECOND:
         begin
            nxt_pc = pc_inc;
            nxt_st = ST_EXEC;
            done   = 1'b1;
            if (op_ff[7:3] == PAT_JMP)
               nxt_pc = {pc_ff[11] ^ bankp_ff, op_ff[2:0], rom_data};
            else if (op_ff[7:3] == PAT_CAL)
            begin
               push   = 1'b1;
               nxt_pc = {1'b0, op_ff[2:0], rom_data};
            end
            else if (op_ff == OP_CTL)
            begin
               if (rom_data[7:4] == CTL_SET_HI || rom_data[7:4] == CTL_CLR_HI)
               begin
                  if (rom_data[3] == 1'b0)
                     nxt_ctl[rom_data[2:0]] = rom_data[4] == 1'b0;
                  else if (rom_data[3:0] == CTL_GLOBAL)
                     nxt_mst = rom_data[4] == 1'b0;
               end
            end
            else if (take)
               nxt_pc = {pc_ff[11:8], rom_data};
         end
         ST_PBIT:
         begin
            nxt_st   = ST_EXEC;
            done     = 1'b1;
            io_we    = 1'b1;
            io_wdata = pbit_val;
            if (op_ff[5])
               nxt_zf = pbit_val == 4'h0;
         end
         ST_HALT:
         begin
            if (wake)
               nxt_st = ST_EXEC;
         end
         default:
            nxt_st = ST_EXEC;
      endcase
   end

   // the bank change mark lives until the next instruction completes
   assign nxt_bankp = (st_ff == ST_EXEC && opc == OP_BANK) ? 1'b1
                    : done ? 1'b0 : bankp_ff;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff    <= ST_EXEC;
         pc_ff    <= RST_PC;
         op_ff    <= OP_NOP;
         acc_ff   <= RST_NIB;
         e_ff     <= RST_NIB;
         dph_ff   <= RST_NIB;
         dpl_ff   <= RST_NIB;
         cf_ff    <= 1'b0;
         zf_ff    <= 1'b0;
         rbf_ff   <= RST_BANK;
         sb_ff    <= RST_BANK;
         bankp_ff <= 1'b0;
         ctl_ff   <= RST_GATES;
         mst_ff   <= 1'b0;
      end
      else
      begin
         st_ff    <= nxt_st;
         pc_ff    <= nxt_pc;
         op_ff    <= nxt_op;
         acc_ff   <= nxt_acc;
         e_ff     <= nxt_e;
         dph_ff   <= nxt_dph;
         dpl_ff   <= nxt_dpl;
         cf_ff    <= nxt_cf;
         zf_ff    <= nxt_zf;
         rbf_ff   <= nxt_rbf;
         sb_ff    <= nxt_sb;
         bankp_ff <= nxt_bankp;
         ctl_ff   <= nxt_ctl;
         mst_ff   <= nxt_mst;
      end
   end

   call_stack #(
      .DEPTH(STACK_DEPTH)
   ) u_stack (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .push      (push),
      .pop       (pop),
      .push_data (pc_inc),
      .top       (top)
   );

   bank_file u_banks (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .bank     (rbf_ff),
      .rd_idx   (rd_idx),
      .rd_data  (rd_data),
      .wr_en    (wr_en),
      .wr_data  (wr_data),
      .flag_idx (flag_idx),
      .flag_we  (flag_we),
      .flag_val (flag_val),
      .flag_rd  (flag_rd),
      .flag_grp (flag_grp)
   );

   // pseudo ports see the whole pointer, real ports only the low nibble
   assign rom_addr         = pc_ff;
   assign mem_addr         = {dph_ff, dpl_ff};
   assign io_pseudo        = bankp_ff;
   assign io_addr          = bankp_ff ? {dph_ff, dpl_ff} : {4'h0, dpl_ff};
   assign standby          = st_ff == ST_HALT;
   assign main_sum_nibble  = acc_ff;
   assign e_nibble         = e_ff;
   assign mem_pointer      = {dph_ff, dpl_ff};
   assign carry_bit        = cf_ff;
   assign zero_bit         = zf_ff;
   assign bank_select_bits = rbf_ff;
   assign irq_gate_bits    = ctl_ff;
   assign global_irq_gate  = mst_ff;
endmodule
`default_nettype wire

// file: testbench/nibble_cpu_core_properties.sv
// Purpose: port-level properties of the decode core
// Assumes: test programs keep second bytes off the checked opcodes
// Notes:   io_we and standby mask cycles that are no fresh first byte
`timescale 1ns/10ps
`default_nettype none
module nibble_cpu_core_checker
   import nibble_cpu_pkg::*;
(
   // clock and reset
   input wire logic            ref_clk,
   input wire logic            rst_n,
   // fetch and port
   input wire logic [PC_W-1:0] rom_addr,
   input wire logic [7:0]      rom_data,
   input wire logic            io_we,
   input wire logic [3:0]      io_wdata,
   input wire logic            standby,
   // state
   input wire logic [3:0]      main_sum_nibble,
   input wire logic [3:0]      e_nibble,
   input wire logic [7:0]      mem_pointer,
   input wire logic            zero_bit
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire ex = !standby && !io_we;
   a_ldz_loads: assert property (ex && rom_data[7:4] == HI_LDZ |=>
      mem_pointer == {4'h0, $past(rom_data[3:0])}) else $error("zero load wrong");
   // a control second byte also starts with 4
   a_lhi_loads: assert property (ex && rom_data[7:4] == HI_LHI && $past(rom_data) != OP_CTL |=>
      mem_pointer[7:4] == $past(rom_data[3:0]) && $stable(mem_pointer[3:0])) else $error("high load wrong");
   a_inc_low: assert property (ex && rom_data == OP_IND |=>
      mem_pointer[3:0] == $past(mem_pointer[3:0]) + 4'h1 && zero_bit == (mem_pointer[3:0] == 4'h0))
      else $error("increment wrong");
   a_tal_copy: assert property (ex && rom_data == OP_TAL |=>
      mem_pointer[3:0] == $past(main_sum_nibble) && $stable(zero_bit)) else $error("transfer wrong");
   a_xah_swap: assert property (ex && rom_data == OP_XAH |=>
      main_sum_nibble == $past(mem_pointer[7:4]) && mem_pointer[7:4] == $past(main_sum_nibble))
      else $error("swap wrong");
   a_port_write: assert property (io_we && rom_data == OP_OP |-> io_wdata == main_sum_nibble)
      else $error("port data wrong");
   a_indexed_page_jump_addr: assert property (ex && rom_data == OP_INDEXED_PAGE_JUMP |=>
      rom_addr == {$past(rom_addr[11:8]), $past(e_nibble), $past(main_sum_nibble)}) else $error("indexed jump wrong");
   a_czp_target: assert property (ex && rom_data[7:4] == HI_CZP |=>
      rom_addr == {6'h00, $past(rom_data[3:0]), 2'h0}) else $error("page call wrong");
   a_halt_stands: assert property (ex && rom_data == OP_HALT |=> standby)
      else $error("halt missing");
   a_nop_idle: assert property (ex && rom_data == OP_NOP |=>
      rom_addr == $past(rom_addr) + 12'h001 && $stable(mem_pointer) && $stable(main_sum_nibble))
      else $error("no-op changed state");
   c_port_write: cover property (io_we && rom_data == OP_OP);
   c_halted: cover property (standby);
   c_indexed: cover property (ex && rom_data == OP_INDEXED_PAGE_JUMP);
endmodule
`default_nettype wire

// file: testbench/io_mem_model.sv
// Purpose: program memory, data memory and ports around the core
// Assumes: reads answer in the same cycle
// Notes:   program bytes are loaded by the bench
`timescale 1ns/10ps
`default_nettype none
module io_mem_model (
   // fetch
   input  wire logic        ref_clk,
   input  wire logic [11:0] rom_addr,
   output logic      [7:0]  rom_data,
   // data memory
   input  wire logic [7:0]  mem_addr,
   output logic      [3:0]  mem_rdata,
   // ports
   input  wire logic [7:0]  io_addr,
   input  wire logic        io_pseudo,
   output logic      [3:0]  io_rdata,
   input  wire logic [3:0]  io_wdata,
   input  wire logic        io_we
);
   logic [7:0] rom [4096];
   logic [3:0] ram [256];
   logic [3:0] io  [512];
   // pseudo ports in the upper half, so they never alias real ports
   wire [8:0] io_sel = {io_pseudo, io_addr};
   assign rom_data  = rom[rom_addr];
   assign mem_rdata = ram[mem_addr];
   assign io_rdata  = io[io_sel];
   initial
   begin
      foreach (ram[i]) ram[i] = 4'h0;
      foreach (io[i]) io[i] = 4'h0;
   end
   always @(posedge ref_clk)
      if (io_we) io[io_sel] <= io_wdata;
endmodule
`default_nettype wire

// file: testbench/nibble_cpu_pointer_branch_decode_tb_top.sv
// Purpose: directed programs through the decode core
// Assumes: first fetch at the first edge after reset release
// Notes:   each scenario restarts from reset with a fresh program
`timescale 1ns/10ps
`default_nettype none
module nibble_cpu_pointer_branch_decode_tb_top;
   logic        ref_clk, rst_n, saved_carry, saved_zero, wake;
   logic [11:0] rom_addr;
   logic [7:0]  rom_data, mem_addr, io_addr, mem_pointer, irq_gate_bits;
   logic [3:0]  mem_rdata, io_rdata, io_wdata, main_sum_nibble, e_nibble;
   logic        io_pseudo, io_we, standby, carry_bit, zero_bit, global_irq_gate;
   logic [1:0]  bank_select_bits;
   int          n_mismatch = 0;
   int          n_compared = 0;
   nibble_cpu_core nibble_cpu_core_i (.ref_clk(ref_clk), .rst_n(rst_n), .rom_addr(rom_addr), .rom_data(rom_data),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .io_addr(io_addr), .io_pseudo(io_pseudo), .io_rdata(io_rdata),
      .io_wdata(io_wdata), .io_we(io_we), .saved_carry(saved_carry), .saved_zero(saved_zero), .standby(standby),
      .wake(wake), .main_sum_nibble(main_sum_nibble), .e_nibble(e_nibble), .mem_pointer(mem_pointer),
      .carry_bit(carry_bit), .zero_bit(zero_bit), .bank_select_bits(bank_select_bits),
      .irq_gate_bits(irq_gate_bits), .global_irq_gate(global_irq_gate));
   io_mem_model io_mem_model_i (.ref_clk(ref_clk), .rom_addr(rom_addr), .rom_data(rom_data), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .io_addr(io_addr), .io_pseudo(io_pseudo), .io_rdata(io_rdata), .io_wdata(io_wdata),
      .io_we(io_we));
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task end_sim;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task ld(input logic [11:0] a, input logic [7:0] q[$]);
      foreach (q[i]) io_mem_model_i.rom[a + 12'(i)] = q[i];
   endtask
   task rst;
      @(negedge ref_clk);
      rst_n = 1'b0;
      for (int i = 0; i < 4096; i++) io_mem_model_i.rom[i] = 8'h00;
   endtask
   // release happens on the first run after a reset
   task run(input int n);
      if (!rst_n)
      begin
         repeat (2) @(negedge ref_clk);
         rst_n = 1'b1;
      end
      repeat (n) @(negedge ref_clk);
   endtask
   task t_ptr;
      rst;
      ld(12'h000, '{8'h85, 8'h4A, 8'hEE, 8'h81, 8'hEF});
      run(3);
      chk("pointer", 12'h0A6, 12'(mem_pointer));
      run(2);
      chk("pointer", 12'h000, 12'(mem_pointer));
      chk("zero", 12'h001, 12'(zero_bit));
   endtask
   task t_xfer;
      rst;
      io_mem_model_i.io[3] = 4'h9;
      ld(12'h000, '{8'h83, 8'h0C, 8'hF7, 8'h4C, 8'h23, 8'hE9, 8'h61});
      run(3);
      chk("sum", 12'h009, 12'(main_sum_nibble));
      chk("pointer", 12'h009, 12'(mem_pointer));
      run(2);
      chk("sum", 12'h00C, 12'(main_sum_nibble));
      chk("pointer", 12'h099, 12'(mem_pointer));
      run(2);
      chk("port", 12'h009, 12'(io_mem_model_i.io[9]));
   endtask
   task t_jump;
      rst;
      saved_carry = 1'b1;
      saved_zero = 1'b1;
      ld(12'h000, '{8'h6B, 8'h34});
      ld(12'h334, '{8'hFD, 8'h6B, 8'h12});
      ld(12'hB12, '{8'hB3, 8'hFA});
      ld(12'h00C, '{8'h22});
      run(2);
      chk("fetch", 12'h334, rom_addr);
      run(3);
      chk("fetch", 12'hB12, rom_addr);
      run(1);
      chk("fetch", 12'h00C, rom_addr);
      run(1);
      chk("fetch", 12'hB13, rom_addr);
      chk("flags", 12'h003, 12'({carry_bit, zero_bit}));
      run(1);
      chk("fetch", 12'hB00, rom_addr);
   endtask
   task t_branch;
      rst;
      ld(12'h000, '{8'h7F, 8'h20});
      ld(12'h020, '{8'h7E, 8'h60, 8'h81, 8'hEF, 8'h7E, 8'h70});
      ld(12'h070, '{8'h3F, 8'h90});
      run(2);
      chk("fetch", 12'h020, rom_addr);
      run(2);
      chk("fetch", 12'h022, rom_addr);
      run(4);
      chk("fetch", 12'h070, rom_addr);
      run(2);
      chk("fetch", 12'h090, rom_addr);
   endtask
   task t_flag;
      rst;
      ld(12'h000, '{8'h66, 8'hF2, 8'h57, 8'hD7, 8'h30});
      ld(12'h030, '{8'h17});
      run(2);
      chk("bank", 12'h002, 12'(bank_select_bits));
      run(3);
      chk("fetch", 12'h030, rom_addr);
      run(1);
      chk("zero", 12'h001, 12'(zero_bit));
   endtask
   task t_ctl;
      rst;
      ld(12'h000, '{8'h2C, 8'h43, 8'h2C, 8'h48, 8'h2C, 8'h49, 8'h2C, 8'h53});
      run(4);
      chk("gates", 12'h108, 12'({global_irq_gate, irq_gate_bits}));
      run(2);
      chk("gates", 12'h108, 12'({global_irq_gate, irq_gate_bits}));
      run(2);
      chk("gates", 12'h100, 12'({global_irq_gate, irq_gate_bits}));
   endtask
   task t_halt;
      rst;
      ld(12'h000, '{8'h05, 8'h79, 8'h06, 8'h00, 8'h00, 8'h00, 8'hF6});
      run(4);
      chk("fetch", 12'h006, rom_addr);
      chk("port", 12'h002, 12'(io_mem_model_i.io[0]));
      run(1);
      chk("standby", 12'h001, 12'(standby));
      wake = 1'b1;
      run(2);
      wake = 1'b0;
      chk("standby", 12'h000, 12'(standby));
   endtask
   initial
   begin
      rst_n = 1'b0;
      wake = 1'b0;
      saved_carry = 1'b0;
      saved_zero = 1'b0;
      t_ptr;
      t_xfer;
      t_jump;
      t_branch;
      t_flag;
      t_ctl;
      t_halt;
      end_sim;
   end
   // whole run is well under a hundred cycles
   initial
   begin
      repeat (2000) @(posedge ref_clk);
      n_mismatch++;
      $display("watchdog expired");
      end_sim;
   end
endmodule
bind nibble_cpu_core nibble_cpu_core_checker nibble_cpu_core_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
   .rom_addr(rom_addr), .rom_data(rom_data), .io_we(io_we), .io_wdata(io_wdata), .standby(standby),
   .main_sum_nibble(main_sum_nibble), .e_nibble(e_nibble), .mem_pointer(mem_pointer), .zero_bit(zero_bit));
`default_nettype wire
